// ===== rtl/epdcd_decoder.v
// Command decoder of the display driver
`timescale 1ns/10ps
`include "epdcd_defs.vh"

// Notes on behaviour
// - Select level routes byte: command or parameter
// - Sleep mode: 00 normal, 01 level1, 11 level2
// - Accepted sleep holds busy high while asleep
// - Soft reinit restores defaults except sleep setting
// - Busy stays high during soft reinit
// - Soft reinit leaves image RAM untouched
// - Command 18 selects temperature source, default 48h
// - Source 80h selects the internal sensor
// - Command 20 runs the enabled update stages
// - Command 22 sets stage enables, default FFh
// - Option 80 clock on only; 01 off only
// - F7: clock, analog, display, analog off, osc off
// - FF adds temperature load before display
// - Command 2F returns one status byte
// - Status bit 5: high voltage not ready
// - Status bit 4: supply below detect level
// - Status bit 2 mirrors busy; bit 3 zero
// - Status bits 1:0 carry chip id
// - Flags valid only after commands 14 and 15
module epdcd_decoder #(
	parameter [1:0] CHIP_ID        = 2'h2,
	parameter       SOFT_CYCLES    = `EPDCD_SOFT_REINIT_CYC,
	parameter       STAGE_CYCLES   = `EPDCD_STAGE_CYC,
	parameter       DISPLAY_CYCLES = `EPDCD_DISPLAY_CYC
) (
	input  wire       core_clk,
	input  wire       reset_n,
	input  wire       bus_addr,
	input  wire [7:0] bus_wdata,
	input  wire       bus_wr,
	input  wire       bus_rd,
	output reg  [7:0] bus_rdata,
	input  wire       hv_not_ready,
	input  wire       supply_low,
	output wire       busy,
	output reg  [8:0] gate_lines_q,
	output reg  [2:0] scan_opt_q,
	output reg  [1:0] sleep_control_setting_q,
	output wire       deep_sleep,
	output reg  [7:0] temp_sel_q,
	output wire       temp_internal,
	output reg  [7:0] update_sequence_setting_q,
	output wire       osc_enable,
	output wire       analog_enable,
	output wire       temp_load,
	output wire       display_run,
	output reg        ram_wr_q,
	output reg  [7:0] ram_wdata_q
);

	localparam ST_IDLE   = 2'h0;
	localparam ST_REINIT = 2'h1;
	localparam ST_UPDATE = 2'h2;
	localparam ST_SLEEP  = 2'h3;

	reg  [1:0]  state_q;
	reg  [1:0]  state_d;
	reg  [7:0]  cmd_q;
	reg  [1:0]  param_idx_q;
	reg  [31:0] reinit_cnt_q;
	reg         hv_valid_q;
	reg         supply_valid_q;
	reg         seq_start;
	wire        seq_busy;
	wire        cmd_wr;
	wire        data_wr;
	wire [7:0]  status_byte;
	wire        accept;
	reg         seq_start_q;
	wire        is_soft;
	wire        is_activate;
	wire        is_hv_init;
	wire        is_supply_init;
	wire        first_param;
	wire        gate_p0;
	wire        gate_p1;
	wire        gate_p2;
	wire        sleep_p0;
	wire        temp_p0;
	wire        opt_p0;
	wire        sleep_entry;

	// Commands and parameters are taken only while idle
	assign accept  = (state_q == ST_IDLE);
	assign cmd_wr  = bus_wr && accept && (bus_addr == `EPDCD_ADDR_CMD);
	assign data_wr = bus_wr && accept && (bus_addr == `EPDCD_ADDR_DATA);

	// Command strobes, one per decoded code
	assign is_soft        = cmd_wr && (bus_wdata == `EPDCD_CMD_SOFT_REINIT);
	assign is_activate    = cmd_wr && (bus_wdata == `EPDCD_CMD_ACTIVATE);
	assign is_hv_init     = cmd_wr && (bus_wdata == `EPDCD_CMD_HV_INIT);
	assign is_supply_init = cmd_wr && (bus_wdata == `EPDCD_CMD_SUPPLY_INIT);

	// Parameter strobes; the index saturates so extra bytes fall through
	assign first_param = data_wr && (param_idx_q == 2'h0);
	assign gate_p0     = first_param && (cmd_q == `EPDCD_CMD_GATE);
	assign gate_p1     = data_wr && (param_idx_q == 2'h1) && (cmd_q == `EPDCD_CMD_GATE);
	assign gate_p2     = data_wr && (param_idx_q == 2'h2) && (cmd_q == `EPDCD_CMD_GATE);
	assign sleep_p0    = first_param && (cmd_q == `EPDCD_CMD_SLEEP);
	assign temp_p0     = first_param && (cmd_q == `EPDCD_CMD_TEMP_SEL);
	assign opt_p0      = first_param && (cmd_q == `EPDCD_CMD_UPDATE_OPT);

	// Only the two sleep levels leave normal operation; value 10 is kept but inert
	assign sleep_entry = sleep_p0 &&
	                     ((bus_wdata[1:0] == `EPDCD_SLEEP_LEVEL1) ||
	                      (bus_wdata[1:0] == `EPDCD_SLEEP_LEVEL2));

	assign busy = (state_q != ST_IDLE);
	assign deep_sleep = (state_q == ST_SLEEP);
	assign temp_internal = (temp_sel_q == `EPDCD_TEMP_INTERNAL);

	// Status byte layout
	assign status_byte = {2'b00,
	                      hv_valid_q & hv_not_ready,
	                      supply_valid_q & supply_low,
	                      1'b0,
	                      busy,
	                      CHIP_ID};

	// Next operating state
	always @* begin
		state_d   = state_q;
		seq_start = 1'b0;
		case (state_q)
			ST_IDLE: begin
				if (is_soft) begin
					state_d = ST_REINIT;
				end else if (is_activate) begin
					state_d   = ST_UPDATE;
					seq_start = 1'b1;
				end else if (sleep_entry) begin
					state_d = ST_SLEEP;
				end
			end
			ST_REINIT: begin
				if (reinit_cnt_q + 32'h1 >= SOFT_CYCLES)
					state_d = ST_IDLE;
			end
			ST_UPDATE: begin
				// The sequencer sees start in the entry cycle; wait for it to finish
				if (!seq_busy && !seq_start_q)
					state_d = ST_IDLE;
			end
			ST_SLEEP: begin
				state_d = ST_SLEEP;
			end
			default: state_d = ST_IDLE;
		endcase
	end

	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q     <= ST_IDLE;
			seq_start_q <= 1'b0;
		end else begin
			state_q     <= state_d;
			seq_start_q <= seq_start;
		end
	end

	// Soft reinit duration; cleared whenever the state is left
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			reinit_cnt_q <= 32'h0;
		end else if (state_q == ST_REINIT) begin
			reinit_cnt_q <= reinit_cnt_q + 32'h1;
		end else begin
			reinit_cnt_q <= 32'h0;
		end
	end

	// Current command and parameter position
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			cmd_q       <= `EPDCD_CMD_NONE;
			param_idx_q <= 2'h0;
		end else if (cmd_wr) begin
			cmd_q       <= bus_wdata;
			param_idx_q <= 2'h0;
		end else if (data_wr && param_idx_q != 2'h3) begin
			param_idx_q <= param_idx_q + 2'h1;
		end
	end

	// Gate line count, low byte then top bit
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			gate_lines_q <= `EPDCD_GATE_LINES_RST;
		end else if (is_soft) begin
			gate_lines_q <= `EPDCD_GATE_LINES_RST;
		end else if (gate_p0) begin
			gate_lines_q[7:0] <= bus_wdata;
		end else if (gate_p1) begin
			gate_lines_q[8] <= bus_wdata[0];
		end
	end

	// Gate scan options, third gate parameter
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			scan_opt_q <= `EPDCD_SCAN_OPT_RST;
		end else if (is_soft) begin
			scan_opt_q <= `EPDCD_SCAN_OPT_RST;
		end else if (gate_p2) begin
			scan_opt_q <= bus_wdata[2:0];
		end
	end

	// Sleep setting; soft reinit leaves it alone on purpose
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			sleep_control_setting_q <= `EPDCD_SLEEP_RST;
		end else if (sleep_p0) begin
			sleep_control_setting_q <= bus_wdata[1:0];
		end
	end

	// Temperature source select
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			temp_sel_q <= `EPDCD_TEMP_SEL_RST;
		end else if (is_soft) begin
			temp_sel_q <= `EPDCD_TEMP_SEL_RST;
		end else if (temp_p0) begin
			temp_sel_q <= bus_wdata;
		end
	end

	// Update stage enables, captured by the sequencer at activation
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			update_sequence_setting_q <= `EPDCD_UPDATE_OPT_RST;
		end else if (is_soft) begin
			update_sequence_setting_q <= `EPDCD_UPDATE_OPT_RST;
		end else if (opt_p0) begin
			update_sequence_setting_q <= bus_wdata;
		end
	end

	// Detection flags mean nothing until the host has initiated them
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			hv_valid_q     <= 1'b0;
			supply_valid_q <= 1'b0;
		end else if (is_soft) begin
			hv_valid_q     <= 1'b0;
			supply_valid_q <= 1'b0;
		end else begin
			if (is_hv_init)
				hv_valid_q <= 1'b1;
			if (is_supply_init)
				supply_valid_q <= 1'b1;
		end
	end

	// Image data bytes pass through untouched by soft reinit
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			ram_wr_q    <= 1'b0;
			ram_wdata_q <= 8'h0;
		end else begin
			ram_wr_q <= data_wr && (cmd_q != `EPDCD_CMD_GATE) &&
			            (cmd_q != `EPDCD_CMD_SLEEP) &&
			            (cmd_q != `EPDCD_CMD_TEMP_SEL) &&
			            (cmd_q != `EPDCD_CMD_UPDATE_OPT) &&
			            (cmd_q != `EPDCD_CMD_NONE);
			if (data_wr)
				ram_wdata_q <= bus_wdata;
		end
	end

	// Read data one cycle after the strobe; status only after command 2F
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			bus_rdata <= 8'h0;
		end else if (bus_rd && bus_addr == `EPDCD_ADDR_DATA &&
		             cmd_q == `EPDCD_CMD_STATUS) begin
			bus_rdata <= status_byte;
		end else begin
			bus_rdata <= 8'h0;
		end
	end

	// Update stages follow the option captured at activation
	epdcd_update_seq #(
		.STAGE_CYCLES   (STAGE_CYCLES),
		.DISPLAY_CYCLES (DISPLAY_CYCLES)
	) u_seq (
		.core_clk    (core_clk),
		.reset_n     (reset_n),
		.start       (seq_start),
		.option      (update_sequence_setting_q),
		.clk_on_q    (osc_enable),
		.analog_on_q (analog_enable),
		.temp_load_q (temp_load),
		.display_q   (display_run),
		.busy        (seq_busy)
	);

endmodule // epdcd_decoder

// ===== rtl/epdcd_defs.vh
// Constants of the display driver command decoder
`ifndef EPDCD_DEFS_VH
`define EPDCD_DEFS_VH

// Bus address: command byte or parameter byte
`define EPDCD_ADDR_CMD          1'b0
`define EPDCD_ADDR_DATA         1'b1

// Command codes
`define EPDCD_CMD_GATE          8'h01
`define EPDCD_CMD_SLEEP         8'h10
`define EPDCD_CMD_SOFT_REINIT   8'h12
`define EPDCD_CMD_HV_INIT       8'h14
`define EPDCD_CMD_SUPPLY_INIT   8'h15
`define EPDCD_CMD_TEMP_SEL      8'h18
`define EPDCD_CMD_ACTIVATE      8'h20
`define EPDCD_CMD_UPDATE_OPT    8'h22
`define EPDCD_CMD_STATUS        8'h2f
`define EPDCD_CMD_NONE          8'h00

// Reset values
`define EPDCD_GATE_LINES_RST    9'h107
`define EPDCD_SCAN_OPT_RST      3'h0
`define EPDCD_SLEEP_RST         2'h0
`define EPDCD_TEMP_SEL_RST      8'h48
`define EPDCD_UPDATE_OPT_RST    8'hff

// Parameter values
`define EPDCD_SLEEP_LEVEL1      2'h1
`define EPDCD_SLEEP_LEVEL2      2'h3
`define EPDCD_TEMP_INTERNAL     8'h80

// Status byte field positions
`define EPDCD_ST_HV_BIT         5
`define EPDCD_ST_SUPPLY_BIT     4
`define EPDCD_ST_BUSY_BIT       2

// Update option stage bits
`define EPDCD_OPT_CLK_ON        7
`define EPDCD_OPT_ANA_ON        6
`define EPDCD_OPT_TEMP_LOAD     3
`define EPDCD_OPT_DISPLAY       2
`define EPDCD_OPT_ANA_OFF       1
`define EPDCD_OPT_CLK_OFF       0

// Timing
`define EPDCD_CLK_MHZ           100
`define EPDCD_SOFT_REINIT_NS    2000
`define EPDCD_SOFT_REINIT_CYC   ((`EPDCD_SOFT_REINIT_NS * `EPDCD_CLK_MHZ + 999) / 1000)
`define EPDCD_STAGE_NS          500
`define EPDCD_STAGE_CYC         ((`EPDCD_STAGE_NS * `EPDCD_CLK_MHZ + 999) / 1000)
`define EPDCD_DISPLAY_CYC       20000

`endif

// ===== rtl/epdcd_update_seq.v
// Display update stage sequencer
`timescale 1ns/10ps
`include "epdcd_defs.vh"

module epdcd_update_seq #(
	parameter STAGE_CYCLES   = `EPDCD_STAGE_CYC,
	parameter DISPLAY_CYCLES = `EPDCD_DISPLAY_CYC
) (
	input  wire       core_clk,
	input  wire       reset_n,
	input  wire       start,
	input  wire [7:0] option,
	output reg        clk_on_q,
	output reg        analog_on_q,
	output reg        temp_load_q,
	output reg        display_q,
	output wire       busy
);

	localparam ST_IDLE = 1'b0;
	localparam ST_RUN  = 1'b1;

	reg        state_q;
	reg [2:0]  stage_q;
	reg [31:0] timer_q;
	reg [7:0]  opt_q;
	reg        stage_en;
	reg [31:0] stage_len;

	assign busy = (state_q == ST_RUN);

	// Stage order: clock on, analog on, temp load, display, analog off, clock off
	always @* begin
		stage_en  = 1'b0;
		stage_len = STAGE_CYCLES;
		case (stage_q)
			3'd0: stage_en = opt_q[`EPDCD_OPT_CLK_ON];
			3'd1: stage_en = opt_q[`EPDCD_OPT_ANA_ON];
			3'd2: stage_en = opt_q[`EPDCD_OPT_TEMP_LOAD];
			3'd3: begin
				stage_en  = opt_q[`EPDCD_OPT_DISPLAY];
				stage_len = DISPLAY_CYCLES;
			end
			3'd4: stage_en = opt_q[`EPDCD_OPT_ANA_OFF];
			3'd5: stage_en = opt_q[`EPDCD_OPT_CLK_OFF];
			default: stage_en = 1'b0;
		endcase
	end

	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q     <= ST_IDLE;
			stage_q     <= 3'h0;
			timer_q     <= 32'h0;
			opt_q       <= 8'h0;
			clk_on_q    <= 1'b0;
			analog_on_q <= 1'b0;
			temp_load_q <= 1'b0;
			display_q   <= 1'b0;
		end else begin
			temp_load_q <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					if (start) begin
						state_q <= ST_RUN;
						stage_q <= 3'h0;
						timer_q <= 32'h0;
						opt_q   <= option;
					end
				end
				ST_RUN: begin
					if (!stage_en || timer_q + 32'h1 >= stage_len) begin
						timer_q   <= 32'h0;
						display_q <= 1'b0;
						if (stage_q == 3'd5)
							state_q <= ST_IDLE;
						else
							stage_q <= stage_q + 3'h1;
					end else begin
						timer_q <= timer_q + 32'h1;
					end
					if (stage_en && timer_q == 32'h0) begin
						case (stage_q)
							3'd0: clk_on_q    <= 1'b1;
							3'd1: analog_on_q <= 1'b1;
							3'd2: temp_load_q <= 1'b1;
							3'd3: display_q   <= (stage_len > 32'h1);
							3'd4: analog_on_q <= 1'b0;
							3'd5: clk_on_q    <= 1'b0;
							default: clk_on_q <= clk_on_q;
						endcase
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

endmodule // epdcd_update_seq

// ===== testbench/epdcd_assertions.sv
// Property checker for the display driver command decoder
`timescale 1ns/10ps
module epdcd_assertions #(
	parameter [1:0] CHIP_ID = 2'h2
) (
	input wire       core_clk,
	input wire       reset_n,
	input wire       bus_addr,
	input wire [7:0] bus_wdata,
	input wire       bus_wr,
	input wire       bus_rd,
	input wire [7:0] bus_rdata,
	input wire       busy,
	input wire [8:0] gate_lines_q,
	input wire [1:0] sleep_control_setting_q,
	input wire       deep_sleep,
	input wire [7:0] temp_sel_q,
	input wire       temp_internal,
	input wire [7:0] update_sequence_setting_q
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	wire cmd_wr = bus_wr && !bus_addr && !busy;
	property p_route;
		cmd_wr && bus_wdata == 8'h18 ##1 bus_wr && bus_addr |=> temp_sel_q == $past(bus_wdata);
	endproperty
	a_route: assert property (p_route) else $error("parameter byte not stored");
	property p_temp_int;
		temp_internal == (temp_sel_q == 8'h80);
	endproperty
	a_temp_int: assert property (p_temp_int) else $error("sensor select wrong");
	property p_soft;
		cmd_wr && bus_wdata == 8'h12 |=> busy && gate_lines_q == 9'h107 && temp_sel_q == 8'h48
			&& update_sequence_setting_q == 8'hff && $stable(sleep_control_setting_q);
	endproperty
	a_soft: assert property (p_soft) else $error("soft reinit defaults wrong");
	property p_sleep_enter;
		cmd_wr && bus_wdata == 8'h10 ##1 bus_wr && bus_addr && bus_wdata[0] |=> deep_sleep && busy;
	endproperty
	a_sleep_enter: assert property (p_sleep_enter) else $error("sleep not entered");
	property p_sleep_hold;
		deep_sleep |=> deep_sleep && busy;
	endproperty
	a_sleep_hold: assert property (p_sleep_hold) else $error("sleep left early");
	property p_refuse;
		busy && bus_wr |=> $stable(temp_sel_q) && $stable(update_sequence_setting_q);
	endproperty
	a_refuse: assert property (p_refuse) else $error("write taken while busy");
	property p_status;
		cmd_wr && bus_wdata == 8'h2f ##1 bus_rd && bus_addr |=> bus_rdata[7:6] == 2'h0
			&& !bus_rdata[3] && bus_rdata[2] == $past(busy) && bus_rdata[1:0] == CHIP_ID;
	endproperty
	a_status: assert property (p_status) else $error("status byte wrong");
	property p_activate;
		cmd_wr && bus_wdata == 8'h20 |=> busy;
	endproperty
	a_activate: assert property (p_activate) else $error("update not started");
endmodule // epdcd_assertions

bind epdcd_decoder epdcd_assertions #(.CHIP_ID(CHIP_ID)) u_chk (.core_clk, .reset_n, .bus_addr,
	.bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .busy, .gate_lines_q, .sleep_control_setting_q,
	.deep_sleep, .temp_sel_q, .temp_internal, .update_sequence_setting_q);

// ===== testbench/epdcd_host_model.sv
// Host controller model driving the command port
`timescale 1ns/10ps
module epdcd_host_model (
	input  wire       core_clk,
	input  wire       busy,
	input  wire [7:0] bus_rdata,
	output reg        bus_addr,
	output reg  [7:0] bus_wdata,
	output reg        bus_wr,
	output reg        bus_rd
);
	initial begin
		bus_addr = 1'b0;
		bus_wdata = 8'h00;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
	end
	task send(input a, input [7:0] d);
		begin
			bus_addr <= a;
			bus_wdata <= d;
			bus_wr <= 1'b1;
			bus_rd <= 1'b0;
			@(posedge core_clk);
		end
	endtask
	task read(output [7:0] v);
		begin
			bus_addr <= 1'b1;
			bus_wr <= 1'b0;
			bus_rd <= 1'b1;
			@(posedge core_clk);
			bus_rd <= 1'b0;
			#1 v = bus_rdata;
		end
	endtask
	// Released data lines do not keep the last byte
	task idle;
		begin
			bus_wr <= 1'b0;
			bus_rd <= 1'b0;
			bus_wdata <= ~bus_wdata;
			@(posedge core_clk);
		end
	endtask
	task wait_ready;
		integer n;
		begin
			for (n = 0; n < 300 && busy; n = n + 1)
				@(posedge core_clk);
		end
	endtask
endmodule // epdcd_host_model

// ===== testbench/test_epaper_command_decoder.sv
// Self-checking bench of the display driver command decoder
`timescale 1ns/10ps
module test_epaper_command_decoder;
	localparam [1:0] CID = 2'h2;
	reg        core_clk, reset_n, hv_not_ready, supply_low;
	wire       bus_addr, bus_wr, bus_rd, busy, deep_sleep, temp_internal, ram_wr_q;
	wire       osc_enable, analog_enable, temp_load, display_run;
	wire [7:0] bus_wdata, bus_rdata, temp_sel_q, update_sequence_setting_q, ram_wdata_q;
	wire [8:0] gate_lines_q;
	wire [2:0] scan_opt_q;
	wire [1:0] sleep_control_setting_q;
	integer    bad_count, cmp_count, i, n;
	reg [7:0]  st;
	reg [23:0] seq;
	reg        po, pa, pd;
	epdcd_decoder #(.SOFT_CYCLES(4), .STAGE_CYCLES(2), .DISPLAY_CYCLES(8)) dut (.core_clk, .reset_n,
		.bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .hv_not_ready, .supply_low, .busy,
		.gate_lines_q, .scan_opt_q, .sleep_control_setting_q, .deep_sleep, .temp_sel_q,
		.temp_internal, .update_sequence_setting_q, .osc_enable, .analog_enable, .temp_load,
		.display_run, .ram_wr_q, .ram_wdata_q);
	epdcd_host_model host (.core_clk, .busy, .bus_rdata, .bus_addr, .bus_wdata, .bus_wr, .bus_rd);
	task check(input string what, input [23:0] exp, input [23:0] got);
		begin
			cmp_count = cmp_count + 1;
			if (got !== exp) begin
				bad_count = bad_count + 1;
				$display("unexpected %0s: expected %h seen %h", what, exp, got);
			end
		end
	endtask
	task rd_st;
		begin
			host.send(1'b0, 8'h2f);
			host.read(st);
			host.idle;
			#1;
		end
	endtask
	task t_defaults;
		begin
			check("gate", 9'h107, gate_lines_q);
			check("scan", 3'h0, scan_opt_q);
			check("sleep", 2'h0, sleep_control_setting_q);
			check("temp", 8'h48, temp_sel_q);
			check("option", 8'hff, update_sequence_setting_q);
			rd_st;
			check("status", {6'h0, CID}, st);
			$display("defaults done");
		end
	endtask
	task t_gate_temp;
		begin
			host.send(1'b0, 8'h01);
			host.send(1'b1, 8'h2b);
			host.send(1'b1, 8'h01);
			host.send(1'b1, 8'h05);
			host.send(1'b1, 8'hff);
			host.send(1'b0, 8'h18);
			host.send(1'b1, 8'h80);
			host.send(1'b1, 8'h12);
			host.idle;
			#1;
			check("gate", 9'h12b, gate_lines_q);
			check("scan", 3'h5, scan_opt_q);
			check("temp", 8'h80, temp_sel_q);
			check("internal", 1'b1, temp_internal);
			check("busy", 1'b0, busy);
			$display("gate and temp done");
		end
	endtask
	task t_flags;
		begin
			host.send(1'b0, 8'h14);
			host.send(1'b0, 8'h15);
			rd_st;
			check("status", {4'h3, 2'h0, CID}, st);
			hv_not_ready <= 1'b0;
			rd_st;
			check("status", {4'h1, 2'h0, CID}, st);
			$display("flags done");
		end
	endtask
	task t_soft;
		begin
			host.send(1'b0, 8'h22);
			host.send(1'b1, 8'h80);
			host.send(1'b0, 8'h10);
			host.send(1'b1, 8'h02);
			host.send(1'b0, 8'h24);
			host.send(1'b1, 8'h5a);
			#1 check("ram write", 1'b1, ram_wr_q);
			host.send(1'b0, 8'h12);
			host.send(1'b0, 8'h18);
			host.send(1'b1, 8'h80);
			host.idle;
			#1 check("busy", 1'b1, busy);
			check("option", 8'hff, update_sequence_setting_q);
			check("sleep", 2'h2, sleep_control_setting_q);
			check("ram data", 8'h5a, ram_wdata_q);
			repeat (5) @(posedge core_clk);
			#1 check("busy", 1'b0, busy);
			check("temp", 8'h48, temp_sel_q);
			rd_st;
			check("status", {6'h0, CID}, st);
			$display("soft reinit done");
		end
	endtask
	task t_update;
		reg [7:0]  opt [0:3];
		reg [23:0] exp [0:3];
		begin
			opt[0] = 8'h80; exp[0] = 24'h1;
			opt[1] = 8'h01; exp[1] = 24'h6;
			opt[2] = 8'hf7; exp[2] = 24'h12456;
			opt[3] = 8'hff; exp[3] = 24'h123456;
			for (i = 0; i < 4; i = i + 1) begin
				po = osc_enable;
				pa = analog_enable;
				pd = display_run;
				seq = 24'h0;
				host.send(1'b0, 8'h22);
				host.send(1'b1, opt[i]);
				host.send(1'b0, 8'h20);
				host.idle;
				#1 check("update busy", 1'b1, busy);
				for (n = 0; n < 200 && busy; n = n + 1) begin
					if (osc_enable && !po) seq = {seq[19:0], 4'h1};
					if (analog_enable && !pa) seq = {seq[19:0], 4'h2};
					if (temp_load) seq = {seq[19:0], 4'h3};
					if (display_run && !pd) seq = {seq[19:0], 4'h4};
					if (!analog_enable && pa) seq = {seq[19:0], 4'h5};
					if (!osc_enable && po) seq = {seq[19:0], 4'h6};
					po = osc_enable;
					pa = analog_enable;
					pd = display_run;
					@(posedge core_clk);
					#1;
				end
				check("stages", exp[i], seq);
				host.wait_ready;
			end
			$display("update done");
		end
	endtask
	task t_sleep;
		reg [7:0] code [0:2];
		begin
			code[0] = 8'h00;
			code[1] = 8'h01;
			code[2] = 8'h03;
			for (i = 0; i < 3; i = i + 1) begin
				host.send(1'b0, 8'h10);
				host.send(1'b1, code[i]);
				host.idle;
				#1 check("asleep", i != 0, deep_sleep);
				check("busy", i != 0, busy);
				host.send(1'b0, 8'h12);
				host.idle;
				repeat (8) @(posedge core_clk);
				#1 check("still asleep", i != 0, deep_sleep);
				reset_n <= 1'b0;
				@(posedge core_clk);
				reset_n <= 1'b1;
				@(posedge core_clk);
				#1 check("awake", 1'b0, deep_sleep);
			end
			$display("sleep done");
		end
	endtask
	task tally_and_finish;
		begin
			$display("compared %0d mismatched %0d", cmp_count, bad_count);
			if (bad_count == 0 && cmp_count > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	initial begin
		bad_count = 0;
		cmp_count = 0;
		reset_n = 1'b0;
		hv_not_ready = 1'b1;
		supply_low = 1'b1;
		repeat (3) @(posedge core_clk);
		reset_n <= 1'b1;
		@(posedge core_clk);
		#1 t_defaults;
		t_gate_temp;
		t_flags;
		t_soft;
		t_update;
		t_sleep;
		tally_and_finish;
	end
	initial begin
		#200000 bad_count = bad_count + 1;
		tally_and_finish;
	end
endmodule // test_epaper_command_decoder
